// [logic/rip_top.sv]
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
// Behaviour
// (R01) four reset sources, three are malfunction
// (R02) malfunction reset held at most 24 periods
// (R03) malfunction circuit may pulse after power-up
// (R04) reset clears enables and latches only
// (R05) reset clears timing divider, watchdog stays on
// (R06) external party holds pin low 12 periods
// (R07) reset release starts at top vector
// (R08) fetch into protected areas raises trap
// (R09) trap gives reset or interrupt by select
// (R10) illegal oscillator stop forces clock reset
// (R11) 24 sources, four non-maskable
// (R12) request sets pending latch, latch requests cpu
// (R13) maskable needs master and own enable
// (R14) fixed priority, lowest number wins
// (R15) vectors for reset, soft, trap, watchdog
// (R16) maskable vectors descend by two
// (R17) trap selector defaults to reset
// (R18) watchdog selector defaults to reset
// (R19) nesting allowed after master re-enable
// (R20) acceptance clears the source latch
// (R21) acceptance saves and clears master enable
// (R22) writing zero clears latch, one ignored
// (R23) present vector of best enabled request
// (R24) any reset source drives single internal reset
`include "rip_defines.svh"

module rip_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic resetPinN,
  input wire logic wdogOverflow,
  input wire logic [23:4] srcReq,
  input rip_pkg::rip_cpu_req_t cpuReq,
  output rip_pkg::rip_cpu_rsp_t cpuRsp,
  output logic timingClear,
  output logic wdogEnable,
  output logic fastOscEnable,
  output logic slowOscEnable,
  output logic clockSelect,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import rip_pkg::*;

  // lowest set index of the candidate vector, valid flag in bit 5
  function automatic logic [5:0] ripPick(input logic [23:0] cand);
    logic [5:0] res;
    res = 6'h00;
    for (int i = 23; i >= 0; i--)
    begin
      if (cand[i])
      begin
        res = {1'b1, 5'(i)};
      end
    end
    return res;
  endfunction

  // vector of a source index; index 0 and 1 fall on the low base too
  function automatic logic [15:0] ripVector(input logic [4:0] idx);
    logic [15:0] vec;
    vec = `RIP_VEC_RESET - {10'h000, idx, 1'b0};
    if (idx >= `RIP_IDX_HIGH)
    begin
      vec = `RIP_VEC_HIGH - {10'h000, idx - `RIP_IDX_HIGH, 1'b0};
    end
    return vec;
  endfunction

  function automatic logic ripInRange(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  rip_ctrl_t ctrl;
  rip_sysctl_t sysctl;
  rip_rst_state_t rstState;
  logic [23:4] enable;
  logic [23:2] pending;
  logic [`RIP_STACK_DEPTH-1:0] imfStack;
  logic [3:0] stackDepth;
  logic [4:0] malfCnt;
  logic [3:0] extLowCnt;
  logic [3:0] lastCause;
  logic pinMeta;
  logic pinSync;
  logic irqReqR;
  logic [15:0] irqVectorR;
  logic [4:0] selIdx;

  // reset pin crosses in through two flops, only the second is read
  always_ff @(posedge clk)
  begin
    pinMeta <= resetPinN;
    pinSync <= pinMeta;
  end

  // external pin qualified after the documented low time
  wire extLowLong = (extLowCnt == 4'(`RIP_EXT_CYC)); // [R06]
  always_ff @(posedge clk)
  begin
    if (srst || pinSync)
      extLowCnt <= 4'h0;
    else if (!extLowLong)
      extLowCnt <= extLowCnt + 4'h1;
  end

  // reset sources and the single internal reset
  wire malfActive = (malfCnt != 5'h00);
  wire extHold = !pinSync && extLowLong;
  wire coreReset = srst || extHold || malfActive; // [R24]

  // address trap: fetch into protected windows
  wire inSfr = ripInRange(cpuReq.fetchAddr, `RIP_SFR_LO, `RIP_SFR_HI);
  wire inDbr = ripInRange(cpuReq.fetchAddr, `RIP_DBR_LO, `RIP_DBR_HI);
  wire inRam = ripInRange(cpuReq.fetchAddr, `RIP_RAM_LO, `RIP_RAM_HI);
  wire trapHit = cpuReq.fetchValid && !coreReset && (inSfr || inDbr || (inRam && ctrl.ram_trap_select)); // [R08]
  wire trapReset = trapHit && ctrl.trap_action_select; // [R09]
  wire trapIrqSet = trapHit && !ctrl.trap_action_select; // [R09]
  wire wdogFire = wdogOverflow && !coreReset && ctrl.wdogEnable;
  wire wdogReset = wdogFire && ctrl.wdog_action_select;
  wire wdogIrqSet = wdogFire && !ctrl.wdog_action_select;

  // apb decode, zero wait states
  wire hitCtrl = (paddr == `RIP_OFS_CTRL);
  wire hitEnable = (paddr == `RIP_OFS_ENABLE);
  wire hitPending = (paddr == `RIP_OFS_PENDING);
  wire hitSysctl = (paddr == `RIP_OFS_SYSCTL);
  wire hitStatus = (paddr == `RIP_OFS_STATUS);
  wire addrHit = hitCtrl || hitEnable || hitPending || hitSysctl || hitStatus;
  wire apbAccess = psel && penable;
  // writes during the internal reset are dropped so reset values hold
  wire wrEn = apbAccess && pwrite && !coreReset;
  wire wrCtrl = wrEn && hitCtrl;
  wire wrEnable = wrEn && hitEnable;
  wire wrPending = wrEn && hitPending;
  wire wrSysctl = wrEn && hitSysctl;

  // clock reset when a write would stop the running oscillator
  rip_sysctl_t sysNew;
  assign sysNew = pwdata[2:0];
  wire fastFall = sysctl.fastOscEnable && !sysNew.fastOscEnable;
  wire slowFall = sysctl.slowOscEnable && !sysNew.slowOscEnable;
  wire clkCase = (fastFall && slowFall) || (fastFall && !sysNew.clockSelect) || (slowFall && sysNew.clockSelect);
  wire clkReset = wrSysctl && clkCase; // [R10]
  wire malfEvent = trapReset || wdogReset || clkReset; // [R01]

  // malfunction hold; srst loads it too, standing for the power-up pulse
  always_ff @(posedge clk)
  begin
    if (srst)
      malfCnt <= 5'(`RIP_MALF_CYC); // [R03]
    else if (malfEvent)
      malfCnt <= 5'(`RIP_MALF_CYC); // [R02]
    else if (malfActive)
      malfCnt <= malfCnt - 5'h01;
  end

  // last count of the hold; a fresh event in that cycle keeps the sequencer in the hold
  wire malfLast = (malfCnt == 5'h01) && !malfEvent;

  // reset sequencer state, visible in status
  always_ff @(posedge clk)
  begin
    if (srst)
      rstState <= RIP_MALF_HOLD;
    else
    begin
      case (rstState)
        RIP_RUN:
          if (extHold)
            rstState <= RIP_EXT_HOLD;
          else if (malfEvent)
            rstState <= RIP_MALF_HOLD;
        RIP_EXT_HOLD:
          if (pinSync)
            rstState <= malfActive ? RIP_MALF_HOLD : RIP_RUN; // [R07]
        RIP_MALF_HOLD:
          if (extHold)
            rstState <= RIP_EXT_HOLD;
          else if (malfLast)
            rstState <= RIP_RUN;
        default:
          rstState <= RIP_RUN;
      endcase
    end
  end

  // cause of the latest reset, only srst clears it
  always_ff @(posedge clk)
  begin
    if (srst)
      lastCause <= 4'h0;
    else if (extHold || malfEvent)
      lastCause <= {clkReset, wdogReset, trapReset, extHold};
  end

  // candidates: soft and illegal share index 1, traps are non-maskable
  logic [23:0] cand;
  assign cand[0] = 1'b0;
  assign cand[`RIP_IDX_SOFT] = cpuReq.soft_irq || cpuReq.illegal_op_irq; // [R11]
  assign cand[`RIP_IDX_TRAP] = pending[`RIP_IDX_TRAP];
  assign cand[`RIP_IDX_WDOG] = pending[`RIP_IDX_WDOG];
  assign cand[`RIP_IDX_EXT0] = pending[`RIP_IDX_EXT0] && ctrl.master_irq_enable && enable[`RIP_IDX_EXT0]
    && ctrl.ext0_pin_enable; // [R13]
  assign cand[23:5] = pending[23:5] & enable[23:5] & {19{ctrl.master_irq_enable}}; // [R13]

  wire [5:0] pick = ripPick(cand); // [R14] [R23]
  wire accept = irqReqR && cpuReq.ack && !coreReset;
  wire acceptLatched = accept && (selIdx >= `RIP_IDX_TRAP);

  // pending latches: hardware set wins over an ack or software clear in the same cycle
  wire [23:2] irqSet = {srcReq, wdogIrqSet, trapIrqSet}; // [R12]
  wire [23:2] ackClr = acceptLatched ? (22'h000001 << (selIdx - `RIP_IDX_TRAP)) : 22'h000000; // [R20]
  wire [23:2] swClr = wrPending ? ~pwdata[23:2] : 22'h000000; // [R22]
  wire [23:2] next_pending = (pending & ~(ackClr | swClr)) | irqSet;
  always_ff @(posedge clk)
  begin
    if (coreReset)
      pending <= 22'h000000; // [R04]
    else
      pending <= next_pending;
  end

  // request and vector to the core, held in flops so both match at ack
  always_ff @(posedge clk)
  begin
    if (coreReset)
    begin
      irqReqR <= 1'b0;
      irqVectorR <= `RIP_VEC_RESET; // [R07] [R15]
      selIdx <= 5'h00;
    end
    else
    begin
      irqReqR <= pick[5] && !accept;
      irqVectorR <= ripVector(pick[4:0]); // [R15] [R16]
      selIdx <= pick[4:0];
    end
  end

  // individual enables
  always_ff @(posedge clk)
  begin
    if (coreReset)
      enable <= 20'h00000; // [R04]
    else if (wrEnable)
      enable <= pwdata[23:4];
  end

  // control bits; acceptance and return own the master enable, but a write in
  // the same cycle still lands in the other bits instead of being lost
  wire stackFull = (stackDepth == 4'(`RIP_STACK_DEPTH));
  wire doReti = cpuReq.reti && !coreReset && !accept && (stackDepth != 4'h0);
  rip_ctrl_t ctrlWr;
  rip_ctrl_t next_ctrl;
  assign ctrlWr = wrCtrl ? rip_ctrl_t'(pwdata[5:0]) : ctrl;
  // master enable sits in bit 0 of the control word
  wire next_master = accept ? 1'b0 // [R21]
    : doReti ? imfStack[0] // [R19] [R21]
    : ctrlWr.master_irq_enable;
  assign next_ctrl = {ctrlWr[5:1], next_master};
  always_ff @(posedge clk)
  begin
    if (coreReset)
      ctrl <= `RIP_CTRL_RESET; // [R04] [R05] [R17] [R18]
    else
      ctrl <= next_ctrl;
  end

  // saved master enable stack; overflow drops the oldest entry
  always_ff @(posedge clk)
  begin
    if (coreReset)
    begin
      imfStack <= '0;
      stackDepth <= 4'h0;
    end
    else if (accept)
    begin
      imfStack <= {imfStack[`RIP_STACK_DEPTH-2:0], ctrl.master_irq_enable}; // [R21]
      stackDepth <= stackFull ? stackDepth : stackDepth + 4'h1;
    end
    else if (doReti)
    begin
      imfStack <= {1'b0, imfStack[`RIP_STACK_DEPTH-1:1]};
      stackDepth <= stackDepth - 4'h1;
    end
  end

  // oscillator control; an offending write is not applied, the clock reset it raises reloads the reset value
  always_ff @(posedge clk)
  begin
    if (coreReset)
      sysctl <= `RIP_SYSCTL_RESET;
    else if (wrSysctl && !clkCase)
      sysctl <= sysNew; // [R10]
  end

  // read mux, data registered in the setup phase
  // status: state, stack depth, cause, request, index, vector from the top bit down
  wire [31:0] statusWord = {rstState, stackDepth, lastCause, irqReqR, selIdx, irqVectorR};
  wire [31:0] readMux = hitCtrl ? {26'h0000000, ctrl}
    : hitEnable ? {8'h00, enable, 4'h0}
    : hitPending ? {8'h00, pending, 2'h0}
    : hitSysctl ? {29'h00000000, sysctl}
    : hitStatus ? statusWord
    : 32'h00000000;
  always_ff @(posedge clk)
  begin
    if (srst)
      prdata <= 32'h00000000;
    else if (psel && !penable)
      prdata <= readMux;
  end

  assign pready = 1'b1;
  assign pslverr = apbAccess && !addrHit; // unmapped answers an error

  // outputs
  assign cpuRsp.coreReset = coreReset;
  assign cpuRsp.irqReq = irqReqR;
  assign cpuRsp.irqVector = irqVectorR;
  assign timingClear = coreReset; // [R05]
  assign wdogEnable = ctrl.wdogEnable; // [R05]
  assign fastOscEnable = sysctl.fastOscEnable;
  assign slowOscEnable = sysctl.slowOscEnable;
  assign clockSelect = sysctl.clockSelect;

endmodule // rip_top

// [logic/rip_defines.svh]
`ifndef RIP_DEFINES_SVH
`define RIP_DEFINES_SVH

// register byte offsets
`define RIP_OFS_CTRL 12'h000
`define RIP_OFS_ENABLE 12'h004
`define RIP_OFS_PENDING 12'h008
`define RIP_OFS_SYSCTL 12'h00c
`define RIP_OFS_STATUS 12'h010

// control register reset value: action selectors on reset request, watchdog on
`define RIP_CTRL_RESET 6'h2c

// system control two reset value: fast oscillator on, slow off, fast clock selected
`define RIP_SYSCTL_RESET 3'h1

// source index layout
`define RIP_IDX_SOFT 5'd1
`define RIP_IDX_TRAP 5'd2
`define RIP_IDX_WDOG 5'd3
`define RIP_IDX_EXT0 5'd4
`define RIP_IDX_LAST 5'd23
`define RIP_IDX_HIGH 5'd16

// vector bases, two bytes per source
`define RIP_VEC_RESET 16'hfffe
`define RIP_VEC_HIGH 16'hffbe

// address trap windows (defaults, arbitrary placement)
`define RIP_SFR_LO 16'h0000
`define RIP_SFR_HI 16'h003f
`define RIP_RAM_LO 16'h0040
`define RIP_RAM_HI 16'h083f
`define RIP_DBR_LO 16'h0f80
`define RIP_DBR_HI 16'h0fff

// timing: figures in fast clock periods, clk runs at the fast clock rate
`define RIP_CLK_PER_FC 1
`define RIP_MALF_FC 24
`define RIP_EXT_FC 12
`define RIP_MALF_CYC (`RIP_MALF_FC * `RIP_CLK_PER_FC)
`define RIP_EXT_CYC (`RIP_EXT_FC * `RIP_CLK_PER_FC)

// saved master enable stack depth
`define RIP_STACK_DEPTH 8

`endif

// [logic/rip_pkg.sv]
package rip_pkg;

  // software control bits, top bit first
  typedef struct packed {
    logic wdogEnable;
    logic ext0_pin_enable;
    logic wdog_action_select;
    logic trap_action_select;
    logic ram_trap_select;
    logic master_irq_enable;
  } rip_ctrl_t;

  // oscillator control, top bit first
  typedef struct packed {
    logic clockSelect;
    logic slowOscEnable;
    logic fastOscEnable;
  } rip_sysctl_t;

  // requests from the cpu core
  typedef struct packed {
    logic fetchValid;
    logic [15:0] fetchAddr;
    logic soft_irq;
    logic illegal_op_irq;
    logic ack;
    logic reti;
  } rip_cpu_req_t;

  // answer to the cpu core
  typedef struct packed {
    logic coreReset;
    logic irqReq;
    logic [15:0] irqVector;
  } rip_cpu_rsp_t;

  typedef enum logic [1:0] {
    RIP_RUN,
    RIP_EXT_HOLD,
    RIP_MALF_HOLD
  } rip_rst_state_t;

endpackage

// [verif/rip_chk.sv]
`timescale 1ns/100ps
module rip_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic resetPinN,
  input rip_pkg::rip_cpu_req_t cpuReq,
  input rip_pkg::rip_cpu_rsp_t cpuRsp,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr
);
  import rip_pkg::*;
  logic [4:0] lowCnt;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // consecutive low pin cycles, saturating so a long reset never wraps
  always_ff @(posedge clk)
    lowCnt <= resetPinN ? 5'h00 : lowCnt + {4'h0, lowCnt != 5'h1f};
  // release of reset and the malfunction hold that follows it
  a_release_hold: assert property ($fell(srst) |-> cpuRsp.coreReset [*8] ##[1:20] !cpuRsp.coreReset)
    else $error("reset hold after release out of bounds");
  a_release_vector: assert property ($fell(srst) |-> cpuRsp.irqVector == 16'hfffe && !cpuRsp.irqReq)
    else $error("reset vector not presented");
  a_pin_reset: assert property (lowCnt == 5'h10 |-> cpuRsp.coreReset)
    else $error("long pin low gave no reset");
  a_pin_release: assert property ($rose(resetPinN) |-> ##[1:6] !cpuRsp.coreReset)
    else $error("reset not released after pin high");
  a_reset_quiet: assert property (cpuRsp.coreReset |=> !cpuRsp.irqReq)
    else $error("request raised under reset");
  // acceptance and vectors
  a_ack_clears: assert property (cpuReq.ack && cpuRsp.irqReq && !cpuRsp.coreReset |=> !cpuRsp.irqReq)
    else $error("request still up after acceptance");
  a_vec_legal: assert property (cpuRsp.irqReq |-> !cpuRsp.irqVector[0] &&
    cpuRsp.irqVector inside {[16'hffb0:16'hffbe], [16'hffe0:16'hfffc]})
    else $error("illegal vector presented");
  // register bus answers
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_bad_addr: assert property (psel && penable && paddr > 12'h010 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule // rip_chk

bind rip_top rip_chk u_rip_chk (.clk, .srst, .resetPinN, .cpuReq, .cpuRsp, .psel, .penable, .paddr,
  .prdata, .pready, .pslverr);

// [verif/rip_cpu_model.sv]
`timescale 1ns/100ps
module rip_cpu_model (
  input wire logic clk,
  input wire logic enable,
  input wire logic slow,
  input rip_pkg::rip_cpu_rsp_t cpuRsp,
  output logic ack,
  output logic [15:0] lastVec,
  output int accepts
);
  import rip_pkg::*;
  int waitCnt;
  initial
  begin
    ack = 1'b0;
    lastVec = 16'h0000;
    accepts = 0;
    waitCnt = 0;
  end
  // one ack pulse per standing request; a stall lets the vector change first
  always @(posedge clk)
  begin
    ack <= 1'b0;
    if (ack)
    begin
      waitCnt <= 0;
      if (cpuRsp.irqReq)
      begin
        lastVec <= cpuRsp.irqVector;
        accepts <= accepts + 1;
      end
    end
    else if (enable && cpuRsp.irqReq && !cpuRsp.coreReset)
    begin
      waitCnt <= waitCnt + 1;
      ack <= (waitCnt >= (slow ? 4 : 0));
    end
    else
      waitCnt <= 0;
  end
endmodule // rip_cpu_model

// [verif/reset_and_interrupt_priority_tb.sv]
`timescale 1ns/100ps
module reset_and_interrupt_priority_tb;
  import rip_pkg::*;
  logic clk = 0, srst = 1, resetPinN = 1, wdogOverflow = 0, fetchValid = 0, softIrq = 0, illegalIrq = 0;
  logic reti = 0, psel = 0, penable = 0, pwrite = 0, mdlEn = 0, mdlSlow = 0, errv, ack;
  logic [23:4] srcReq = '0;
  logic [15:0] fetchAddr = '0, lastVec;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdv, mask, seed = 32'hf26531e8;
  logic pready, pslverr, timingClear, wdogEnable, fastOscEnable, slowOscEnable, clockSelect;
  int accepts, i, n, k, mismatches = 0, total_checks = 0;
  rip_cpu_req_t cpuReq;
  rip_cpu_rsp_t cpuRsp;
  assign cpuReq = {fetchValid, fetchAddr, softIrq, illegalIrq, ack, reti};
  rip_top u_rip_top (.clk, .srst, .resetPinN, .wdogOverflow, .srcReq, .cpuReq, .cpuRsp, .timingClear,
    .wdogEnable, .fastOscEnable, .slowOscEnable, .clockSelect, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  rip_cpu_model u_rip_cpu_model (.clk, .enable(mdlEn), .slow(mdlSlow), .cpuRsp, .ack, .lastVec, .accepts);
  initial forever #2 clk = ~clk;
  // reference helpers: random source sets and the vector of a source index
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] expVec(int idx);
    return (idx < 16) ? 16'hfffe - 16'(2 * idx) : 16'hffde - 16'(2 * idx);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one transfer; no wait count assumed, the hang guard ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask
  task automatic take(input logic [15:0] exp);
    n = accepts;
    mdlEn <= 1'b1;
    for (k = 0; k < 60 && accepts == n; k++) @(posedge clk);
    mdlEn <= 1'b0;
    chk(accepts, n + 1);
    chk(lastVec, exp);
  endtask
  // reset must start soon and end within lim cycles
  task automatic rstSpan(input int lim);
    for (k = 0; k < 8 && cpuRsp.coreReset !== 1'b1; k++) @(negedge clk);
    chk(timingClear, 1'b1);
    for (k = 0; k < 40 && cpuRsp.coreReset === 1'b1; k++) @(negedge clk);
    chk(k <= lim, 1);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, far beyond the expected thousand or so cycles
  initial
  begin
    #200000;
    mismatches++;
    stop_test();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (28) @(posedge clk);
    chk(wdogEnable, 1'b1);
    rd(12'h000, 32'h2c);
    rd(12'h004, 32'h0);
    rd(12'h008, 32'h0);
    rd(12'h00c, 32'h1);
    apb(1'b0, 12'h014, 32'h0);
    chk(rdv, 32'h0);
    chk({31'h0, errv}, 32'h1);
    $display("test registers done");
    apb(1'b1, 12'h004, 32'h00fffff0);
    for (n = 0; n < 3; n++)
    begin
      mask = rnd() & 32'h00fffff0;
      @(posedge clk);
      srcReq <= mask[23:4];
      @(posedge clk);
      srcReq <= '0;
      mdlSlow <= mask[4];
      while (mask != 0)
      begin
        for (i = 4; !mask[i]; i++);
        mask[i] = 1'b0;
        apb(1'b1, 12'h000, 32'h3d);
        take(expVec(i));
        rd(12'h008, mask);
        rd(12'h000, 32'h3c);
      end
    end
    // return from interrupt brings back the master enable saved at acceptance
    @(posedge clk);
    reti <= 1'b1;
    @(posedge clk);
    reti <= 1'b0;
    rd(12'h000, 32'h3d);
    $display("test priority done");
    @(posedge clk);
    srcReq <= 20'h00009;
    @(posedge clk);
    srcReq <= '0;
    apb(1'b1, 12'h000, 32'h2d);
    take(16'hfff0);
    rd(12'h008, 32'h10);
    apb(1'b1, 12'h008, 32'hffffffff);
    rd(12'h008, 32'h10);
    apb(1'b1, 12'h008, 32'h0);
    rd(12'h008, 32'h0);
    for (i = 0; i < 2; i++)
    begin
      {softIrq, illegalIrq} <= i ? 2'b01 : 2'b10;
      take(16'hfffc);
      {softIrq, illegalIrq} <= 2'b00;
      @(posedge clk);
    end
    apb(1'b1, 12'h000, 32'h28);
    @(posedge clk);
    fetchValid <= 1'b1;
    fetchAddr <= 16'h0020;
    @(posedge clk);
    fetchValid <= 1'b0;
    take(16'hfffa);
    apb(1'b1, 12'h000, 32'h24);
    @(posedge clk);
    wdogOverflow <= 1'b1;
    @(posedge clk);
    wdogOverflow <= 1'b0;
    take(16'hfff8);
    $display("test masking done");
    // fetch traps into each protected area, the ram one behind its select
    for (i = 0; i < 3; i++)
    begin
      apb(1'b1, 12'h004, 32'h30);
      apb(1'b1, 12'h000, i ? 32'h2c : 32'h2e);
      @(posedge clk);
      fetchValid <= 1'b1;
      fetchAddr <= i == 0 ? 16'h0100 : i == 1 ? 16'h0010 : 16'h0f80;
      @(posedge clk);
      fetchValid <= 1'b0;
      rstSpan(24);
      rd(12'h004, 32'h0);
      rd(12'h000, 32'h2c);
    end
    // watchdog overflow with the reset-time selector gives a malfunction reset
    @(posedge clk);
    wdogOverflow <= 1'b1;
    @(posedge clk);
    wdogOverflow <= 1'b0;
    rstSpan(24);
    rd(12'h010, 32'h0100fffe);
    // illegal oscillator stops: both, fast on fast clock, slow on slow clock
    for (i = 0; i < 3; i++)
    begin
      apb(1'b1, 12'h00c, 32'h7);
      @(negedge clk);
      chk({clockSelect, slowOscEnable, fastOscEnable}, 32'h7);
      apb(1'b1, 12'h00c, i == 0 ? 32'h0 : i == 1 ? 32'h2 : 32'h5);
      rstSpan(24);
      rd(12'h00c, 32'h1);
      chk(fastOscEnable, 1'b1);
    end
    $display("test malfunction done");
    for (i = 6; i <= 16; i += 10)
    begin
      @(posedge clk);
      resetPinN <= 1'b0;
      repeat (i) @(posedge clk);
      chk(cpuRsp.coreReset, i > 12);
      resetPinN <= 1'b1;
      repeat (6) @(posedge clk);
      chk(cpuRsp.coreReset, 1'b0);
    end
    rd(12'h000, 32'h2c);
    $display("test pin done");
    stop_test();
  end
endmodule // reset_and_interrupt_priority_tb
